// ===== design/hbp_pkg.sv
/*
  Shared constants, state type and byte-lane helpers for the host bus port.
  Assumes a single 100 MHz clock and a synchronous, active-low reset.
*/
package hbp_pkg;

  localparam int         BUS_W         = 32;
  localparam int         CSR_W         = 16;
  localparam int         BYTE_W        = 8;
  localparam int         ADDR_W        = 4;
  localparam int         FIFO_DEPTH    = 16;
  localparam logic [3:0] QUEUE_ADDR    = 4'h0;
  localparam int         MUX_ADDR_LSB  = 2;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         RST_MIN_NS    = 16;
  localparam int         RST_MIN_CYC   =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RST_MIN_CNT   = 4'(RST_MIN_CYC);
  localparam logic [1:0] LAST_LANE_16  = 2'h1;
  localparam logic [1:0] LAST_LANE_32  = 2'h3;

  typedef enum logic [1:0]
  {
    HC_RESET  = 2'h0,
    HC_IDLE   = 2'h1,
    HC_ACCESS = 2'h3
  } hbp_host_state_t;

  // Index of the last byte of a bus word for the latched width.
  function automatic logic [1:0] last_lane(input logic w32);
    return w32 ? LAST_LANE_32 : LAST_LANE_16;
  endfunction

  // Bus byte lane that carries network byte idx of a word.
  function automatic logic [1:0] byte_lane(input logic [1:0] idx,
                                           input logic       le,
                                           input logic       w32);
    return le ? idx : 2'(last_lane(w32) - idx);
  endfunction

  // Network byte idx taken out of a bus word.
  function automatic logic [7:0] lane_byte(input logic [31:0] word,
                                           input logic [1:0]  idx,
                                           input logic        le,
                                           input logic        w32);
    logic [1:0] lane;
    lane = byte_lane(idx, le, w32);
    return word[{lane, 3'h0} +: 8];
  endfunction

endpackage

// ===== design/hbp_stream_if.sv
/*
  Byte stream carrier between the receive FIFO and the word packer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface hbp_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== design/hbp_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous, active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module hbp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  hbp_stream_if.src         pop
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;
  logic         do_push;
  logic         do_pop;

  assign full    = (wr_ptr[AW] != rd_ptr[AW]) &&
                   (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty   = (wr_ptr == rd_ptr);
  assign o_ready = !full;
  assign do_push = i_valid && !full;
  assign do_pop  = pop.ready && !empty;
  assign pop.valid = !empty;
  assign pop.data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/hbp_packer.sv
/*
  Packs the network-order byte stream into host bus words.
  Assumes the width and byte order inputs stay constant outside reset.
*/
`timescale 1ns/10ps
`default_nettype none
module hbp_packer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_w32,
  input  wire logic        i_le,
  hbp_stream_if.snk        s,
  input  wire logic        i_pop,
  output logic [31:0]      o_word,
  output logic             o_valid
);
  logic [1:0]  idx;
  logic [1:0]  lane;
  logic [31:0] acc;
  logic [31:0] next_word;
  logic        take;
  logic        last;

  assign s.ready = !o_valid;
  assign take    = s.valid && !o_valid;
  assign last    = (idx == hbp_pkg::last_lane(i_w32));
  assign lane    = hbp_pkg::byte_lane(idx, i_le, i_w32); // RL8

  always_comb
  begin
    next_word = acc;
    next_word[{lane, 3'h0} +: 8] = s.data; // RL9 RL10 RL11 RL12
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      idx <= 2'h0;
      acc <= 32'h0;
    end
    else if (take)
    begin
      idx <= last ? 2'h0 : 2'(idx + 2'h1);
      acc <= last ? 32'h0 : next_word;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_word  <= 32'h0;
      o_valid <= 1'b0;
    end
    else if (take && last)
    begin
      o_word  <= next_word;
      o_valid <= 1'b1;
    end
    else if (i_pop)
    begin
      o_valid <= 1'b0;
    end
  end

  a_pack_hold: assert property ( // RL8
    @(posedge i_clk) disable iff (!i_rst_n)
    o_valid && !i_pop |=> o_valid && $stable(o_word))
    else $error("Packed word changed before it was read.");

  a_pack_fill: assert property ( // RL3
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_valid) |-> $past(idx) == hbp_pkg::last_lane(i_w32))
    else $error("Word completed with the wrong byte count.");
endmodule
`default_nettype wire

// ===== design/hbp_host_bus_port.sv
/*
  Host bus port: strap capture, bus shape, register and queue data lanes.
  Assumes host strobes and pins are synchronous to I_CLK.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RL1] Capture multiplex select at reset release
// [RL2] Zero separate buses, one shared address/data
// [RL3] Latch width strap, run 16 or 32 bits
// [RL4] Latch byte order strap for queue data
// [RL5] D0 is LSB, MSB per width
// [RL6] Register data never byte swapped
// [RL7] Registers use D15 to D0 only
// [RL8] Queue data packed bytewise in network order
// [RL9] Big endian 16: first byte high
// [RL10] Big endian 32: first byte top lane
// [RL11] Little endian 16: first byte low
// [RL12] Little endian 32: first byte bottom lane
// [RL13] Reset low long enough before strap latch
// [RL14] Straps fixed until next reset release
module hbp_host_bus_port (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_BUS_MUX_SEL,
  input  wire logic        I_SIZE32_STRAP,
  input  wire logic        I_BYTE_ORDER_STRAP,
  input  wire logic        I_HOST_CS_N,
  input  wire logic        I_HOST_RD_N,
  input  wire logic        I_HOST_WR_N,
  input  wire logic        I_HOST_ALE,
  input  wire logic [3:0]  I_HOST_ADDR,
  input  wire logic [31:0] I_HOST_D,
  output logic [31:0]      O_HOST_D,
  output logic             O_HOST_D_OE,
  input  wire logic [7:0]  I_RXQ_BYTE,
  input  wire logic        I_RXQ_VALID,
  output logic             O_RXQ_READY,
  output logic [7:0]       O_TXQ_BYTE,
  output logic             O_TXQ_VALID,
  input  wire logic        I_TXQ_READY,
  output logic             O_TXQ_DROP,
  output logic             O_CSR_REQ,
  output logic             O_CSR_WE,
  output logic [3:0]       O_CSR_ADDR,
  output logic [15:0]      O_CSR_WDATA,
  input  wire logic [15:0] I_CSR_RDATA,
  output logic             O_READY,
  output logic             O_MUX_MODE,
  output logic             O_WIDTH32,
  output logic             O_LITTLE_ENDIAN
);
  hbp_pkg::hbp_host_state_t state;

  logic        rst_q;
  logic [3:0]  rst_cnt;
  logic        latch_now;
  logic        host_acc;
  logic        start;
  logic        rd_start;
  logic        wr_start;
  logic        is_queue;
  logic [3:0]  addr;
  logic [31:0] pk_word;
  logic        pk_valid;
  logic        pk_pop;
  logic [31:0] tx_word;
  logic [1:0]  tx_idx;
  logic [1:0]  next_tx_idx;
  logic [31:0] next_tx_word;

  hbp_stream_if #(.W(hbp_pkg::BYTE_W)) rxs ();

  hbp_fifo #(
    .W     (hbp_pkg::BYTE_W),
    .DEPTH (hbp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_data  (I_RXQ_BYTE),
    .i_valid (I_RXQ_VALID),
    .o_ready (O_RXQ_READY),
    .pop     (rxs)
  );

  hbp_packer u_packer (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_w32   (O_WIDTH32),
    .i_le    (O_LITTLE_ENDIAN),
    .s       (rxs),
    .i_pop   (pk_pop),
    .o_word  (pk_word),
    .o_valid (pk_valid)
  );

  // Straps are taken only on the release of a long enough reset.
  assign latch_now = I_RST_N && !rst_q &&
                     (rst_cnt == hbp_pkg::RST_MIN_CNT); // RL13
  assign O_READY   = (state != hbp_pkg::HC_RESET);
  assign host_acc  = !I_HOST_CS_N && (!I_HOST_RD_N || !I_HOST_WR_N);
  assign start     = (state == hbp_pkg::HC_IDLE) && host_acc;
  assign rd_start  = start && !I_HOST_RD_N;
  assign wr_start  = start && I_HOST_RD_N;
  assign is_queue  = (addr == hbp_pkg::QUEUE_ADDR);
  assign pk_pop    = rd_start && is_queue && pk_valid;
  assign O_CSR_ADDR  = addr;
  assign O_HOST_D_OE = (state == hbp_pkg::HC_ACCESS) &&
                       !I_HOST_CS_N && !I_HOST_RD_N;
  assign next_tx_idx  = 2'(tx_idx + 2'h1);
  assign next_tx_word = O_WIDTH32 ? I_HOST_D : {16'h0, I_HOST_D[15:0]};

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rst_q <= 1'b0;
      if (rst_cnt != hbp_pkg::RST_MIN_CNT)
      begin
        rst_cnt <= 4'(rst_cnt + 4'h1); // RL13
      end
    end
    else
    begin
      rst_q   <= 1'b1;
      rst_cnt <= 4'h0;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_MUX_MODE      <= 1'b0;
      O_WIDTH32       <= 1'b0;
      O_LITTLE_ENDIAN <= 1'b0;
    end
    else if (latch_now) // RL14
    begin
      O_MUX_MODE      <= I_BUS_MUX_SEL; // RL1
      O_WIDTH32       <= I_SIZE32_STRAP; // RL3
      O_LITTLE_ENDIAN <= I_BYTE_ORDER_STRAP; // RL4
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state <= hbp_pkg::HC_RESET;
    end
    else
    begin
      case (state)
        hbp_pkg::HC_RESET:
        begin
          if (latch_now)
          begin
            state <= hbp_pkg::HC_IDLE;
          end
        end
        hbp_pkg::HC_IDLE:
        begin
          if (host_acc)
          begin
            state <= hbp_pkg::HC_ACCESS;
          end
        end
        hbp_pkg::HC_ACCESS:
        begin
          if (!host_acc)
          begin
            state <= hbp_pkg::HC_IDLE;
          end
        end
        default:
        begin
          state <= hbp_pkg::HC_RESET;
        end
      endcase
    end
  end

  // The address follows I_HOST_ADDR, or is latched on ALE, while idle and is frozen during an access.
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      addr <= 4'h0;
    end
    else if (state == hbp_pkg::HC_IDLE && !host_acc)
    begin
      if (O_MUX_MODE) // RL2
      begin
        if (I_HOST_ALE)
        begin
          addr <= I_HOST_D[hbp_pkg::MUX_ADDR_LSB +: hbp_pkg::ADDR_W];
        end
      end
      else
      begin
        addr <= I_HOST_ADDR; // RL2
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_HOST_D <= 32'h0;
    end
    else if (rd_start)
    begin
      if (is_queue)
      begin
        O_HOST_D <= pk_valid ? pk_word : 32'h0; // RL8 RL5
      end
      else
      begin
        O_HOST_D <= {16'h0, I_CSR_RDATA}; // RL6 RL7
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_CSR_REQ   <= 1'b0;
      O_CSR_WE    <= 1'b0;
      O_CSR_WDATA <= 16'h0;
    end
    else
    begin
      O_CSR_REQ <= start && !is_queue;
      O_CSR_WE  <= wr_start && !is_queue;
      if (wr_start && !is_queue)
      begin
        O_CSR_WDATA <= I_HOST_D[15:0]; // RL6 RL7
      end
    end
  end

  // Queue writes are split into network-order bytes.
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      tx_word     <= 32'h0;
      tx_idx      <= 2'h0;
      O_TXQ_BYTE  <= 8'h0;
      O_TXQ_VALID <= 1'b0;
      O_TXQ_DROP  <= 1'b0;
    end
    else
    begin
      O_TXQ_DROP <= 1'b0;
      if (wr_start && is_queue)
      begin
        if (!O_TXQ_VALID)
        begin
          tx_word     <= next_tx_word;
          tx_idx      <= 2'h0;
          O_TXQ_VALID <= 1'b1;
          O_TXQ_BYTE  <= hbp_pkg::lane_byte(next_tx_word, 2'h0,
                           O_LITTLE_ENDIAN, O_WIDTH32); // RL9 RL10 RL11 RL12
        end
        else
        begin
          O_TXQ_DROP <= 1'b1;
        end
      end
      else if (O_TXQ_VALID && I_TXQ_READY)
      begin
        if (tx_idx == hbp_pkg::last_lane(O_WIDTH32))
        begin
          O_TXQ_VALID <= 1'b0;
        end
        else
        begin
          tx_idx     <= next_tx_idx;
          O_TXQ_BYTE <= hbp_pkg::lane_byte(tx_word, next_tx_idx,
                          O_LITTLE_ENDIAN, O_WIDTH32); // RL8
        end
      end
    end
  end

  a_strap_capture: assert property ( // RL1 RL3 RL4
    @(posedge I_CLK) disable iff (!I_RST_N)
    latch_now |=> O_MUX_MODE == $past(I_BUS_MUX_SEL) &&
      O_WIDTH32 == $past(I_SIZE32_STRAP) &&
      O_LITTLE_ENDIAN == $past(I_BYTE_ORDER_STRAP))
    else $error("Straps not captured at reset release.");

  a_strap_stable: assert property ( // RL14
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_READY |=> $stable({O_MUX_MODE, O_WIDTH32, O_LITTLE_ENDIAN}))
    else $error("Strap setting changed during operation.");

  a_reset_min: assert property ( // RL13
    @(posedge I_CLK) disable iff (!I_RST_N)
    $rose(O_READY) |-> $past(rst_cnt) == hbp_pkg::RST_MIN_CNT)
    else $error("Port left reset after a too short pulse.");

  a_mux_addr: assert property ( // RL2
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_MUX_MODE && I_HOST_ALE && state == hbp_pkg::HC_IDLE && !host_acc
    |=> O_CSR_ADDR == $past(I_HOST_D[5:2]))
    else $error("Multiplexed address not latched on ALE.");

  a_sep_addr: assert property ( // RL2
    @(posedge I_CLK) disable iff (!I_RST_N)
    !O_MUX_MODE && state == hbp_pkg::HC_IDLE && !host_acc
    |=> O_CSR_ADDR == $past(I_HOST_ADDR))
    else $error("Separate address bus not followed.");

  a_csr_no_swap: assert property ( // RL6 RL7
    @(posedge I_CLK) disable iff (!I_RST_N)
    rd_start && !is_queue ##1 O_HOST_D_OE
    |-> O_HOST_D == {16'h0, $past(I_CSR_RDATA)})
    else $error("Register read data not on low lanes unswapped.");

  a_csr_write_low: assert property ( // RL7
    @(posedge I_CLK) disable iff (!I_RST_N)
    wr_start && !is_queue |=> O_CSR_REQ && O_CSR_WE &&
      O_CSR_WDATA == $past(I_HOST_D[15:0]))
    else $error("Register write data not taken from D15 to D0.");

  a_q16_upper_zero: assert property ( // RL5
    @(posedge I_CLK) disable iff (!I_RST_N)
    rd_start && is_queue && !O_WIDTH32 |=> O_HOST_D[31:16] == 16'h0)
    else $error("Upper lanes driven in 16-bit mode.");

  a_q_read_word: assert property ( // RL8
    @(posedge I_CLK) disable iff (!I_RST_N)
    pk_pop |=> O_HOST_D == $past(pk_word) && !pk_valid)
    else $error("Queue read did not return and consume the word.");

  a_tx_first_byte: assert property ( // RL9 RL10 RL11 RL12
    @(posedge I_CLK) disable iff (!I_RST_N)
    wr_start && is_queue && !O_TXQ_VALID |=> O_TXQ_VALID &&
      O_TXQ_BYTE == (O_LITTLE_ENDIAN ? $past(I_HOST_D[7:0]) :
      (O_WIDTH32 ? $past(I_HOST_D[31:24]) : $past(I_HOST_D[15:8]))))
    else $error("First queue byte taken from the wrong lane.");

  c_le32_read: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    pk_pop && O_WIDTH32 && O_LITTLE_ENDIAN);
  c_be16_read: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    pk_pop && !O_WIDTH32 && !O_LITTLE_ENDIAN);
  c_tx_drop: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_TXQ_DROP);
  c_mux_csr: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_MUX_MODE && wr_start && !is_queue);
endmodule
`default_nettype wire

// ===== tb/hbp_host_master.sv
/*
  Host processor bus master model for the host bus port.
  Assumes one clock; pins change just after the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module hbp_host_master (
  input  wire logic        i_clk,
  input  wire logic        i_mux,
  input  wire logic [31:0] i_d,
  input  wire logic        i_oe,
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_ale,
  output logic [3:0]       o_addr,
  output logic [31:0]      o_d
);
  initial
  begin
    o_cs_n = 1'h1;
    o_rd_n = 1'h1;
    o_wr_n = 1'h1;
    o_ale  = 1'h0;
    o_addr = 4'hF;
    o_d    = 32'h5A5A_A5A5;
  end

  // Address phase, strobe held over three edges, then release.
  task automatic access(input  logic        wr,
                        input  logic [3:0]  a,
                        input  logic [31:0] wd,
                        output logic [31:0] rd,
                        output logic        oe);
    @(negedge i_clk);
    if (i_mux)
    begin
      o_ale  = 1'h1;
      o_d    = {26'h0, a, 2'h0};
      o_addr = ~a;
    end
    else
    begin
      o_addr = a;
    end
    @(negedge i_clk);
    o_ale = 1'h0;
    o_d   = wr ? wd : ~o_d;
    @(negedge i_clk);
    o_cs_n = 1'h0;
    o_rd_n = wr;
    o_wr_n = ~wr;
    repeat (3) @(negedge i_clk);
    rd     = i_d;
    oe     = i_oe;
    o_cs_n = 1'h1;
    o_rd_n = 1'h1;
    o_wr_n = 1'h1;
    o_d    = ~o_d;
    @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/hbp_host_bus_port_tb_top.sv
/*
  Self-checking bench for the host bus port.
  Assumes the host master model and a sink that accepts except while t_queue stalls it.
*/
`timescale 1ns/10ps
`default_nettype none
module hbp_host_bus_port_tb_top;
  logic        I_CLK, I_RST_N, I_BUS_MUX_SEL, I_SIZE32_STRAP;
  logic        I_BYTE_ORDER_STRAP, I_HOST_CS_N, I_HOST_RD_N, I_HOST_WR_N;
  logic        I_HOST_ALE, I_RXQ_VALID, O_RXQ_READY, O_TXQ_VALID;
  logic        I_TXQ_READY, O_TXQ_DROP, O_CSR_REQ, O_CSR_WE, O_READY;
  logic        O_MUX_MODE, O_WIDTH32, O_LITTLE_ENDIAN, O_HOST_D_OE, oe;
  logic [3:0]  I_HOST_ADDR, O_CSR_ADDR;
  logic [7:0]  I_RXQ_BYTE, O_TXQ_BYTE;
  logic [15:0] O_CSR_WDATA, I_CSR_RDATA, csr_wd;
  logic [31:0] I_HOST_D, O_HOST_D, rd;
  logic        csr_we;
  int          fail_count, n_compared, cycles, csr_pulses, drops;

  hbp_host_bus_port dut (
    .I_CLK (I_CLK), .I_RST_N (I_RST_N), .I_BUS_MUX_SEL (I_BUS_MUX_SEL),
    .I_SIZE32_STRAP (I_SIZE32_STRAP),
    .I_BYTE_ORDER_STRAP (I_BYTE_ORDER_STRAP),
    .I_HOST_CS_N (I_HOST_CS_N), .I_HOST_RD_N (I_HOST_RD_N),
    .I_HOST_WR_N (I_HOST_WR_N), .I_HOST_ALE (I_HOST_ALE),
    .I_HOST_ADDR (I_HOST_ADDR), .I_HOST_D (I_HOST_D),
    .O_HOST_D (O_HOST_D), .O_HOST_D_OE (O_HOST_D_OE),
    .I_RXQ_BYTE (I_RXQ_BYTE), .I_RXQ_VALID (I_RXQ_VALID),
    .O_RXQ_READY (O_RXQ_READY), .O_TXQ_BYTE (O_TXQ_BYTE),
    .O_TXQ_VALID (O_TXQ_VALID), .I_TXQ_READY (I_TXQ_READY),
    .O_TXQ_DROP (O_TXQ_DROP), .O_CSR_REQ (O_CSR_REQ),
    .O_CSR_WE (O_CSR_WE),
    .O_CSR_ADDR (O_CSR_ADDR), .O_CSR_WDATA (O_CSR_WDATA),
    .I_CSR_RDATA (I_CSR_RDATA), .O_READY (O_READY),
    .O_MUX_MODE (O_MUX_MODE), .O_WIDTH32 (O_WIDTH32),
    .O_LITTLE_ENDIAN (O_LITTLE_ENDIAN));

  hbp_host_master host (
    .i_clk (I_CLK), .i_mux (I_BUS_MUX_SEL), .i_d (O_HOST_D),
    .i_oe (O_HOST_D_OE), .o_cs_n (I_HOST_CS_N), .o_rd_n (I_HOST_RD_N),
    .o_wr_n (I_HOST_WR_N), .o_ale (I_HOST_ALE), .o_addr (I_HOST_ADDR),
    .o_d (I_HOST_D));

  // Outside register storage answers from the held address.
  assign I_CSR_RDATA = {4'hA, O_CSR_ADDR, 8'h5C};

  initial
  begin
    I_CLK = 1'h0;
    forever #5 I_CLK = ~I_CLK;
  end

  always @(negedge I_CLK)
  begin
    cycles++;
    if (O_CSR_REQ === 1'h1)
    begin
      csr_pulses++;
      csr_we = O_CSR_WE;
      csr_wd = O_CSR_WDATA;
    end
    if (O_TXQ_DROP === 1'h1)
      drops++;
    if (cycles == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus word holding nb network bytes from base in the given order.
  function automatic logic [31:0] pack(input int base, input int nb,
                                       input logic lit);
    logic [31:0] w;
    w = 32'h0;
    for (int j = 0; j < nb; j++)
      w[(lit ? j : nb - 1 - j) * 8 +: 8] = 8'(base + j);
    return w;
  endfunction

  task automatic do_reset(input logic m, input logic w, input logic l,
                          input int n);
    @(negedge I_CLK);
    I_RST_N = 1'h0;
    I_BUS_MUX_SEL = m;
    I_SIZE32_STRAP = w;
    I_BYTE_ORDER_STRAP = l;
    repeat (n) @(negedge I_CLK);
    I_RST_N = 1'h1;
    repeat (2) @(negedge I_CLK);
  endtask

  // Every strap combination, straps flipped after release, short reset.
  task automatic t_straps();
    logic [2:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s = 3'(i);
      do_reset(s[2], s[1], s[0], 8);
      I_BUS_MUX_SEL = ~s[2];
      I_SIZE32_STRAP = ~s[1];
      I_BYTE_ORDER_STRAP = ~s[0];
      repeat (3) @(negedge I_CLK);
      check(32'(O_READY), 32'h1);
      check(32'(O_MUX_MODE), 32'(s[2]));
      check(32'(O_WIDTH32), 32'(s[1]));
      check(32'(O_LITTLE_ENDIAN), 32'(s[0]));
    end
    do_reset(1'h0, 1'h0, 1'h0, 1);
    repeat (4) @(negedge I_CLK);
    check(32'(O_READY), 32'h0);
  endtask

  // Fill until refused, drain word by word, read empty, write a word and have a second one dropped.
  task automatic t_queue(input logic m, input logic w, input logic l);
    int nb;
    int nw;
    int n;
    nb = w ? 4 : 2;
    nw = 16 / nb + 1;
    do_reset(m, w, l, 8);
    for (int i = 0; i < nw * nb; i++)
    begin
      I_RXQ_BYTE = 8'(i);
      I_RXQ_VALID = 1'h1;
      n = 0;
      while (O_RXQ_READY !== 1'h1 && n < 50)
      begin
        @(negedge I_CLK);
        n++;
      end
      @(negedge I_CLK);
    end
    I_RXQ_VALID = 1'h0;
    repeat (4) @(negedge I_CLK);
    check(32'(O_RXQ_READY), 32'h0);
    for (int k = 0; k <= nw; k++)
    begin
      host.access(1'h0, hbp_pkg::QUEUE_ADDR, 32'h0, rd, oe);
      check(32'(oe), 32'h1);
      check(rd, k < nw ? pack(k * nb, nb, l) : 32'h0);
    end
    drops = 0;
    I_TXQ_READY = 1'h0;
    host.access(1'h1, hbp_pkg::QUEUE_ADDR, pack(8'hA0, nb, l), rd, oe);
    host.access(1'h1, hbp_pkg::QUEUE_ADDR, pack(8'hB0, nb, l), rd, oe);
    I_TXQ_READY = 1'h1;
    for (int j = 0; j < nb; j++)
    begin
      check(32'(O_TXQ_VALID), 32'h1);
      check(32'(O_TXQ_BYTE), 32'(8'hA0 + j));
      @(negedge I_CLK);
    end
    check(32'(O_TXQ_VALID), 32'h0);
    check(32'(drops), 32'h1);
  endtask

  // Register write and read on the low lanes, same in both byte orders.
  task automatic t_csr(input logic l);
    do_reset(l, 1'h1, l, 8);
    csr_pulses = 0;
    host.access(1'h1, 4'h5, 32'hBEEF_1234, rd, oe);
    repeat (2) @(negedge I_CLK);
    check(32'(csr_pulses), 32'h1);
    check(32'(csr_we), 32'h1);
    check(32'(csr_wd), 32'h1234);
    host.access(1'h0, 4'hC, 32'h0, rd, oe);
    repeat (2) @(negedge I_CLK);
    check(rd, {16'h0, 4'hA, 4'hC, 8'h5C});
    check(32'(csr_pulses), 32'h2);
    check(32'(csr_we), 32'h0);
  endtask

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    csr_pulses = 0;
    I_RST_N = 1'h0;
    I_BUS_MUX_SEL = 1'h0;
    I_SIZE32_STRAP = 1'h0;
    I_BYTE_ORDER_STRAP = 1'h0;
    I_RXQ_BYTE = 8'h0;
    I_RXQ_VALID = 1'h0;
    I_TXQ_READY = 1'h1;
    repeat (8) @(negedge I_CLK);
    I_RST_N = 1'h1;
    t_straps();
    t_queue(1'h0, 1'h0, 1'h0);
    t_queue(1'h1, 1'h1, 1'h0);
    t_queue(1'h0, 1'h0, 1'h1);
    t_queue(1'h1, 1'h1, 1'h1);
    t_csr(1'h0);
    t_csr(1'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
